// >>> src/dkc_pkg.sv
// package of shared constants for the disk controller mcu/buffer port,
// plus the three-stage input synchroniser used on every mcu and buffer pin input.
// assumes a single 20 MHz controller clock with synchronous active-high reset.
`timescale 1ns/1ps
package dkc_pkg;
  // controller clock and mcu reset hold
  localparam int CLK_PERIOD_NS   = 50;
  localparam int RST_HOLD_CYCLES = 24;
  // buffer strobe widths in clock cycles
  localparam int WR_PULSE_CYCLES = 2;
  localparam int RD_PULSE_CYCLES = 4;
  // mcu-visible register offsets on the latched address
  localparam logic [7:0] REG_ADDR_LO = 8'h00;
  localparam logic [7:0] REG_ADDR_HI = 8'h01;
  localparam logic [7:0] REG_DATA    = 8'h02;
  localparam logic [7:0] REG_CTRL    = 8'h03;
  localparam logic [7:0] REG_STAT    = 8'h04;
  localparam logic [7:0] REG_IMASK   = 8'h05;
  // field positions
  localparam int CTRL_RD_BIT    = 0;
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_DONE_BIT  = 1;
  localparam int IMASK_DONE_BIT = 0;
  localparam int IMASK_EXT_BIT  = 1;
  // control pin order inside the synchronised vector
  localparam int PIN_ALE    = 0;
  localparam int PIN_PROGRAM_STORE_ENABLE_N_N = 1;
  localparam int PIN_RD_N   = 2;
  localparam int PIN_WR_N   = 3;
  // buffer access sequencer
  typedef enum logic [1:0] {
    BUF_IDLE  = 2'b00,
    BUF_WRITE = 2'b01,
    BUF_READ  = 2'b10
  } dkc_buf_state_t;
endpackage

// three flip-flops per bit; o_agree marks bits whose stages two and three match
module dkc_sync #(
  parameter int           W       = 8,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_reset,
  // asynchronous input
  input  wire logic [W-1:0] i_d,
  // synchronised output
  output logic      [W-1:0] o_q,
  output logic      [W-1:0] o_agree
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } dkc_sync_st_t;

  dkc_sync_st_t st_ff;
  dkc_sync_st_t nxt_st;

  initial begin
    if (W < 1) $error("dkc_sync: width must be at least one");
  end

  // shift chain; s1 feeds only s2 to keep metastability contained
  always_comb begin
    nxt_st    = st_ff;
    nxt_st.s1 = i_d;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      st_ff <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_q     = st_ff.s3;
  assign o_agree = ~(st_ff.s2 ^ st_ff.s3);
endmodule

// >>> src/dkc_port.sv
// mcu slave port and external sram buffer control of the disk controller.
// assumes all mcu and sram pins are asynchronous to I_MCLK and the board
// resolves each bidirectional bus from the output enables.
// one clock domain; every mcu and sram input pin passes a three-stage synchroniser first.
// limitation: reads answer about four clocks after the strobe falls, so the
// mcu must stretch its strobes; address and start writes while busy are dropped silently.
// Functional notes
// - latch address from muxed bus at address strobe fall, drive it out.
// - answer mcu accesses only while program store enable is high.
// - read strobe low, valid address, enable high: drive register data.
// - write strobe rising with valid address, enable high: load register.
// - pull interrupt output low while an interrupt condition is pending.
// - hold mcu reset output active for at least 24 clock cycles.
// - address buffer ram bytewise through sixteen address outputs.
// - bank select output equals inverse of top buffer address bit.
// - buffer write enable low during each buffer write cycle.
// - buffer output enable low during each buffer read cycle.
// - eight bit buffer data bus driven on writes, sampled on reads.
`timescale 1ns/1ps
module dkc_port (
  // clock and reset
  input  wire logic        I_MCLK,
  input  wire logic        I_RESET,
  // microcontroller bus
  input  wire logic        I_ALE,
  input  wire logic        I_PROGRAM_STORE_ENABLE_N_N,
  input  wire logic        I_RD_N,
  input  wire logic        I_WR_N,
  input  wire logic [7:0]  I_MCU_ADDR_DATA_BUS,
  output logic      [7:0]  O_MCU_ADDR_DATA_BUS,
  output logic             O_MCU_ADDR_DATA_OE_N,
  output logic      [7:0]  O_LATCHED_MCU_ADDRESS,
  output logic             O_INT_N,
  output logic             O_MCU_RESET_OUTPUT,
  // event from other controller logic on the same clock
  input  wire logic        I_EXT_EVENT,
  // buffer sram
  input  wire logic [7:0]  I_BUFFER_DATA_BUS,
  output logic      [7:0]  O_BUFFER_DATA_BUS,
  output logic             O_BUFFER_DATA_OE_N,
  output logic      [15:0] O_BUFFER_ADDRESS_BUS,
  output logic             O_UPPER_BANK_SELECT_N,
  output logic             O_BUFFER_WRITE_ENABLE_N,
  output logic             O_BUFFER_OUTPUT_ENABLE_N
);
  // every flop of the port outside the two synchronisers, registered together by one process
  typedef struct packed {
    logic [3:0]              ctl;        // accepted control pin levels
    logic [7:0]              addr;       // latched mcu address
    logic                    addr_valid;
    logic [7:0]              ad_out;
    logic                    ad_oe_n;
    logic [7:0]              wr_data;    // byte waiting to go to the buffer
    logic [7:0]              rd_data;    // last byte read from the buffer
    logic                    done;       // sticky access-complete flag
    logic                    ext_pend;   // sticky external event flag
    logic [1:0]              imask;
    logic                    int_n;
    logic [4:0]              rst_cnt;
    logic                    mcu_rst;
    dkc_pkg::dkc_buf_state_t bstate;
    logic [3:0]              cnt;
    logic [15:0]             ma;
    logic                    bank_n;
    logic                    mwe_n;
    logic                    moe_n;
    logic [7:0]              md_out;
    logic                    md_oe_n;
  } dkc_port_st_t;

  localparam dkc_port_st_t ST_RESET = '{
    ctl: 4'hE, addr: 8'h00, addr_valid: 1'b0, ad_out: 8'h00, ad_oe_n: 1'b1,
    wr_data: 8'h00, rd_data: 8'h00, done: 1'b0, ext_pend: 1'b0, imask: 2'h0,
    int_n: 1'b1, rst_cnt: 5'h00, mcu_rst: 1'b1, bstate: dkc_pkg::BUF_IDLE,
    cnt: 4'h0, ma: 16'h0000, bank_n: 1'b1, mwe_n: 1'b1, moe_n: 1'b1,
    md_out: 8'h00, md_oe_n: 1'b1
  };

  // counter end points, cut on purpose to the counter widths checked below
  localparam logic [3:0]  WE_OFF_CNT  = 4'(dkc_pkg::WR_PULSE_CYCLES - 1);
  localparam logic [3:0]  WR_END_CNT  = 4'(dkc_pkg::WR_PULSE_CYCLES);
  localparam logic [3:0]  RD_MIN_CNT  = 4'(dkc_pkg::RD_PULSE_CYCLES - 1);
  localparam logic [4:0]  RST_END_CNT = 5'(dkc_pkg::RST_HOLD_CYCLES);
  // pin idle levels: muxed bus low, address strobe low, other strobes high
  localparam logic [11:0] MCU_IDLE    = {8'h00, 4'hE};

  initial begin
    if (dkc_pkg::RST_HOLD_CYCLES > 31 || dkc_pkg::RD_PULSE_CYCLES > 15 ||
        dkc_pkg::WR_PULSE_CYCLES > 14 || dkc_pkg::RD_PULSE_CYCLES < 1 ||
        dkc_pkg::WR_PULSE_CYCLES < 1) begin
      $error("dkc_port: timing constants exceed counter width");
    end
  end

  // true when the latched address names a register of this port
  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a == dkc_pkg::REG_ADDR_LO) || (a == dkc_pkg::REG_ADDR_HI) ||
              (a == dkc_pkg::REG_DATA) || (a == dkc_pkg::REG_CTRL) ||
              (a == dkc_pkg::REG_STAT) || (a == dkc_pkg::REG_IMASK);
  endfunction

  // buffer address after a byte access; wraps at the top of the space
  function automatic logic [15:0] next_addr(input logic [15:0] a);
    next_addr = a + 16'h0001;
  endfunction

  dkc_port_st_t st_ff;
  dkc_port_st_t nxt_st;
  logic [11:0]  mcu_q;
  logic [11:0]  mcu_agree;
  logic [7:0]   md_q;
  logic [7:0]   md_agree;

  // mcu pins: control strobes in the low nibble, muxed bus above
  // stages reset to idle levels, so no false strobe edge follows reset
  dkc_sync #(.W(12), .RST_VAL(MCU_IDLE)) u_mcu_sync (
    .i_clk   (I_MCLK),
    .i_reset (I_RESET),
    .i_d     ({I_MCU_ADDR_DATA_BUS, I_WR_N, I_RD_N, I_PROGRAM_STORE_ENABLE_N_N, I_ALE}),
    .o_q     (mcu_q),
    .o_agree (mcu_agree)
  );

  // buffer read data
  // same three stages; a byte is taken only once all its bits agree
  dkc_sync #(.W(8)) u_md_sync (
    .i_clk   (I_MCLK),
    .i_reset (I_RESET),
    .i_d     (I_BUFFER_DATA_BUS),
    .o_q     (md_q),
    .o_agree (md_agree)
  );

  // next-state logic for the whole port
  always_comb begin
    logic [3:0] ctl;
    logic       selected;
    logic       wr_rise;
    logic       start_wr;
    logic       start_rd;
    logic [7:0] din;
    ctl      = st_ff.ctl;
    selected = 1'b0;
    wr_rise  = 1'b0;
    start_wr = 1'b0;
    start_rd = 1'b0;
    din      = mcu_q[11:4];
    nxt_st   = st_ff;

    // a pin change counts only when stages two and three agree
    for (int i = 0; i < 4; i++) begin
      if (mcu_agree[i]) ctl[i] = mcu_q[i];
    end
    nxt_st.ctl = ctl;

    // address capture on strobe fall; bus bits are taken as they stand, with no agree check
    // until the first fall the port stays silent, whatever the address
    if (st_ff.ctl[dkc_pkg::PIN_ALE] && !ctl[dkc_pkg::PIN_ALE]) begin
      nxt_st.addr       = din;
      nxt_st.addr_valid = 1'b1;
    end

    // program fetches never reach the registers
    selected = st_ff.addr_valid && ctl[dkc_pkg::PIN_PROGRAM_STORE_ENABLE_N_N] &&
               reg_hit(st_ff.addr);

    // register read: drive bus while the read strobe stays low
    // data tracks the live register for as long as the strobe is held
    nxt_st.ad_oe_n = 1'b1;
    if (selected && !ctl[dkc_pkg::PIN_RD_N]) begin
      nxt_st.ad_oe_n = 1'b0;
      case (st_ff.addr)
        dkc_pkg::REG_ADDR_LO: nxt_st.ad_out = st_ff.ma[7:0];
        dkc_pkg::REG_ADDR_HI: nxt_st.ad_out = st_ff.ma[15:8];
        dkc_pkg::REG_DATA:    nxt_st.ad_out = st_ff.rd_data;
        dkc_pkg::REG_STAT: begin
          nxt_st.ad_out = 8'h00;
          nxt_st.ad_out[dkc_pkg::STAT_BUSY_BIT] = (st_ff.bstate != dkc_pkg::BUF_IDLE);
          nxt_st.ad_out[dkc_pkg::STAT_DONE_BIT] = st_ff.done;
        end
        dkc_pkg::REG_IMASK:   nxt_st.ad_out = {6'h00, st_ff.imask};
        default:              nxt_st.ad_out = 8'h00;
      endcase
    end

    // register write on rising write strobe; data sampled at that edge
    // address and start writes while busy are dropped; the data byte still lands
    wr_rise = !st_ff.ctl[dkc_pkg::PIN_WR_N] && ctl[dkc_pkg::PIN_WR_N];
    if (selected && wr_rise) begin
      case (st_ff.addr)
        dkc_pkg::REG_ADDR_LO: begin
          if (st_ff.bstate == dkc_pkg::BUF_IDLE) nxt_st.ma[7:0] = din;
        end
        dkc_pkg::REG_ADDR_HI: begin
          if (st_ff.bstate == dkc_pkg::BUF_IDLE) nxt_st.ma[15:8] = din;
        end
        dkc_pkg::REG_DATA: begin
          nxt_st.wr_data = din;
          start_wr       = (st_ff.bstate == dkc_pkg::BUF_IDLE);
        end
        dkc_pkg::REG_CTRL: begin
          start_rd = din[dkc_pkg::CTRL_RD_BIT] && (st_ff.bstate == dkc_pkg::BUF_IDLE);
        end
        dkc_pkg::REG_STAT: begin
          if (din[dkc_pkg::STAT_DONE_BIT]) nxt_st.done = 1'b0;
          if (din[dkc_pkg::STAT_DONE_BIT]) nxt_st.ext_pend = 1'b0;
        end
        dkc_pkg::REG_IMASK:   nxt_st.imask = din[1:0];
        default:              nxt_st.imask = st_ff.imask;
      endcase
    end

    // buffer sequencer; writes hold data one cycle past the strobe
    // one access at a time; status busy tells the mcu when to poll again
    case (st_ff.bstate)
      dkc_pkg::BUF_IDLE: begin
        nxt_st.cnt = 4'h0;
        if (start_wr) begin
          nxt_st.bstate  = dkc_pkg::BUF_WRITE;
          nxt_st.md_out  = din;
          nxt_st.md_oe_n = 1'b0;
          nxt_st.mwe_n   = 1'b0;
        end else if (start_rd) begin
          nxt_st.bstate = dkc_pkg::BUF_READ;
          nxt_st.moe_n  = 1'b0;
        end
      end
      dkc_pkg::BUF_WRITE: begin
        nxt_st.cnt = st_ff.cnt + 4'h1;
        // strobe rises first, so the ram latches while the data still stands
        if (st_ff.cnt == WE_OFF_CNT) begin
          nxt_st.mwe_n = 1'b1;
        end
        if (st_ff.cnt == WR_END_CNT) begin
          nxt_st.md_oe_n = 1'b1;
          nxt_st.bstate  = dkc_pkg::BUF_IDLE;
          nxt_st.ma      = next_addr(st_ff.ma);
          nxt_st.done    = 1'b1;
        end
      end
      dkc_pkg::BUF_READ: begin
        nxt_st.cnt = st_ff.cnt + 4'h1;
        // strobe long enough for the three-stage input path to settle
        if (st_ff.cnt >= RD_MIN_CNT && (&md_agree)) begin
          nxt_st.rd_data = md_q;
          nxt_st.moe_n   = 1'b1;
          nxt_st.bstate  = dkc_pkg::BUF_IDLE;
          nxt_st.ma      = next_addr(st_ff.ma);
          nxt_st.done    = 1'b1;
        end
      end
      // unused state code: back to idle with every strobe released
      default: begin
        nxt_st.bstate  = dkc_pkg::BUF_IDLE;
        nxt_st.mwe_n   = 1'b1;
        nxt_st.moe_n   = 1'b1;
        nxt_st.md_oe_n = 1'b1;
      end
    endcase

    // bank select follows the next address so both leave the same flop edge
    // the top address bit picks the second ram, whose enable is low-active
    nxt_st.bank_n = ~nxt_st.ma[15];

    // sticky external event; a new event beats a same-cycle clear
    if (I_EXT_EVENT) nxt_st.ext_pend = 1'b1;

    // interrupt line low while any unmasked flag is pending
    // a level, not a pulse: it stays low until the flag or its mask is cleared
    nxt_st.int_n = ~((nxt_st.done && nxt_st.imask[dkc_pkg::IMASK_DONE_BIT]) ||
                     (nxt_st.ext_pend && nxt_st.imask[dkc_pkg::IMASK_EXT_BIT]));

    // mcu reset stretcher; counts from release of I_RESET, not from power-up
    // the output drops one edge after the count reaches its end
    if (st_ff.rst_cnt != RST_END_CNT) begin
      nxt_st.rst_cnt = st_ff.rst_cnt + 5'h01;
      nxt_st.mcu_rst = 1'b1;
    end else begin
      nxt_st.mcu_rst = 1'b0;
    end
  end

  // single state register, synchronous reset
  // one register for all port state outside the synchronisers keeps reset and next state in one place
  always_ff @(posedge I_MCLK) begin
    if (I_RESET) begin
      st_ff <= ST_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from the state register
  // no logic between flop and pin, so the pins never glitch
  assign O_MCU_ADDR_DATA_BUS      = st_ff.ad_out;
  assign O_MCU_ADDR_DATA_OE_N     = st_ff.ad_oe_n;
  assign O_LATCHED_MCU_ADDRESS    = st_ff.addr;
  assign O_INT_N                  = st_ff.int_n;
  assign O_MCU_RESET_OUTPUT       = st_ff.mcu_rst;
  assign O_BUFFER_DATA_BUS        = st_ff.md_out;
  assign O_BUFFER_DATA_OE_N       = st_ff.md_oe_n;
  assign O_BUFFER_ADDRESS_BUS     = st_ff.ma;
  assign O_UPPER_BANK_SELECT_N    = st_ff.bank_n;
  assign O_BUFFER_WRITE_ENABLE_N  = st_ff.mwe_n;
  assign O_BUFFER_OUTPUT_ENABLE_N = st_ff.moe_n;
endmodule

// >>> bench/dkc_port_assertions.sv
// checks on the mcu port and buffer sram pins of dkc_port.
// assumes one clock with synchronous active-high reset; bound onto dkc_port.
`timescale 1ns/1ps
module dkc_port_assertions (
  // clock and reset
  input wire logic        I_MCLK,
  input wire logic        I_RESET,
  // mcu side
  input wire logic        I_RD_N,
  input wire logic        I_PROGRAM_STORE_ENABLE_N_N,
  input wire logic        O_MCU_ADDR_DATA_OE_N,
  input wire logic        O_MCU_RESET_OUTPUT,
  // buffer side
  input wire logic [15:0] O_BUFFER_ADDRESS_BUS,
  input wire logic        O_UPPER_BANK_SELECT_N,
  input wire logic        O_BUFFER_WRITE_ENABLE_N,
  input wire logic        O_BUFFER_OUTPUT_ENABLE_N,
  input wire logic        O_BUFFER_DATA_OE_N
);
  default clocking cb @(posedge I_MCLK);
  endclocking
  default disable iff (I_RESET);
  // edges since release; saturates so a long run never wraps under the hold
  logic [5:0] rel_cnt_ff;
  logic [5:0] nxt_rel_cnt;
  assign nxt_rel_cnt = (rel_cnt_ff == 6'h3F) ? rel_cnt_ff : rel_cnt_ff + 6'h01;
  always_ff @(posedge I_MCLK) begin
    rel_cnt_ff <= I_RESET ? 6'h00 : nxt_rel_cnt;
  end
  // high through the 24th edge after release, low from the 25th on
  AST_RST_HOLD: assert property (rel_cnt_ff < 6'h19 |-> O_MCU_RESET_OUTPUT)
    else $error("mcu reset dropped early");
  AST_RST_DROP: assert property (rel_cnt_ff >= 6'h19 |-> !O_MCU_RESET_OUTPUT)
    else $error("mcu reset held too long");
  AST_BANK: assert property (O_UPPER_BANK_SELECT_N == !O_BUFFER_ADDRESS_BUS[15])
    else $error("bank select mismatch");
  AST_NO_BOTH: assert property (O_BUFFER_WRITE_ENABLE_N || O_BUFFER_OUTPUT_ENABLE_N)
    else $error("both buffer strobes low");
  AST_DATA_REL: assert property (!O_BUFFER_DATA_OE_N |->
    !O_BUFFER_WRITE_ENABLE_N || !$past(O_BUFFER_WRITE_ENABLE_N)) else $error("data bus held");
  AST_WE_WIDTH: assert property ($fell(O_BUFFER_WRITE_ENABLE_N) |->
    ##1 !O_BUFFER_WRITE_ENABLE_N ##1 O_BUFFER_WRITE_ENABLE_N) else $error("write strobe width");
  AST_OE_WIDTH: assert property ($fell(O_BUFFER_OUTPUT_ENABLE_N) |->
    (!O_BUFFER_OUTPUT_ENABLE_N)[*4] ##[1:8] O_BUFFER_OUTPUT_ENABLE_N) else $error("read width");
  AST_ADDR_HOLD: assert property (!(O_BUFFER_WRITE_ENABLE_N && O_BUFFER_OUTPUT_ENABLE_N) |->
    $stable(O_BUFFER_ADDRESS_BUS)) else $error("address moved in access");
  AST_MCU_RD: assert property ($fell(O_MCU_ADDR_DATA_OE_N) |->
    !$past(I_RD_N, 4) && $past(I_PROGRAM_STORE_ENABLE_N_N, 4)) else $error("mcu bus driven without read");
  AST_MCU_FETCH: assert property ((!I_PROGRAM_STORE_ENABLE_N_N)[*6] |-> O_MCU_ADDR_DATA_OE_N)
    else $error("mcu bus driven in fetch");
  // main scenarios reached
  COV_WR: cover property ($fell(O_BUFFER_WRITE_ENABLE_N));
  COV_RD: cover property ($fell(O_BUFFER_OUTPUT_ENABLE_N));
  COV_MCU: cover property ($fell(O_MCU_ADDR_DATA_OE_N));
endmodule
bind dkc_port dkc_port_assertions u_chk (.*);

// >>> bench/dkc_sram_model.sv
// behavioural byte-wide static ram on the buffer pins.
// assumes the port under test is the only party driving its strobes.
`timescale 1ns/1ps
module dkc_sram_model #(
  parameter int DLY = 40
) (
  // strobes and address
  input  wire logic        we_n,
  input  wire logic        oe_n,
  input  wire logic        doe_n,
  input  wire logic [15:0] addr,
  // data
  input  wire logic [7:0]  wdata,
  output logic      [7:0]  rdata
);
  logic [7:0] mem [0:65535];
  logic [7:0] last = 8'h00;
  // store on strobe release; an undriven data bus lands as garbage
  always @(posedge we_n) begin
    mem[addr] = (doe_n === 1'b0) ? wdata : ~wdata;
  end
  // slow answer; a released bus shows the inverse of its last value
  always @(oe_n or addr) begin
    if (oe_n === 1'b0) begin
      #DLY;
      rdata = mem[addr];
      last = rdata;
    end else begin
      rdata = ~last;
    end
  end
endmodule

// >>> bench/tb_dkc_port.sv
// bench for dkc_port: mcu register cycles, buffer traffic, refusals, interrupts.
// assumes the sram model and the checker bind are compiled beside it.
`timescale 1ns/1ps
module tb_dkc_port;
  typedef struct {logic [15:0] a; logic [7:0] d; logic [15:0] nxt;} dkc_row_t;
  // bench-driven pins
  logic        mclk = 1'b0, reset = 1'b1, ale = 1'b0, program_store_enable_n_n = 1'b1;
  logic        rd_n = 1'b1, wr_n = 1'b1, ext = 1'b0, drv = 1'b0;
  logic [7:0]  dval = 8'h00;
  // design outputs
  logic [7:0]  mcu_q, lat, b_wd, b_rd, q;
  logic [15:0] b_addr;
  logic        mcu_oe_n, int_n, mrst, b_doe_n, bank_n, we_n, oe_n;
  // pull-down on the mcu bus, so an undriven cycle reads zero
  wire  [7:0]  mcu_bus = (mcu_oe_n === 1'b0) ? mcu_q : (drv ? dval : 8'h00);
  wire  [7:0]  b_bus = (b_doe_n === 1'b0) ? b_wd : b_rd;
  int          n_fail = 0, n_checks = 0, cyc = 0, n = 0;
  dkc_row_t    rows [4] = '{'{16'h0000, 8'hA5, 16'h0001}, '{16'h7FFF, 8'h3C, 16'h8000},
                            '{16'hFFFF, 8'hFF, 16'h0000}, '{16'h1234, 8'h5A, 16'h1235}};
  dkc_port dut (
    .I_MCLK(mclk), .I_RESET(reset), .I_ALE(ale), .I_PROGRAM_STORE_ENABLE_N_N(program_store_enable_n_n), .I_RD_N(rd_n),
    .I_WR_N(wr_n), .I_MCU_ADDR_DATA_BUS(mcu_bus), .O_MCU_ADDR_DATA_BUS(mcu_q),
    .O_MCU_ADDR_DATA_OE_N(mcu_oe_n), .O_LATCHED_MCU_ADDRESS(lat), .O_INT_N(int_n),
    .O_MCU_RESET_OUTPUT(mrst), .I_EXT_EVENT(ext), .I_BUFFER_DATA_BUS(b_bus),
    .O_BUFFER_DATA_BUS(b_wd), .O_BUFFER_DATA_OE_N(b_doe_n), .O_BUFFER_ADDRESS_BUS(b_addr),
    .O_UPPER_BANK_SELECT_N(bank_n), .O_BUFFER_WRITE_ENABLE_N(we_n),
    .O_BUFFER_OUTPUT_ENABLE_N(oe_n));
  dkc_sram_model #(.DLY(40)) sram (.we_n(we_n), .oe_n(oe_n), .doe_n(b_doe_n),
    .addr(b_addr), .wdata(b_wd), .rdata(b_rd));
  // clock and hang guard
  always #25 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      end_of_test;
    end
  end
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one mcu cycle; strobes held 7 edges, address and data held past them
  task automatic mcu_cyc(input logic wr, input logic ps, input logic [7:0] a,
                         input logic [7:0] d, output logic [7:0] rq);
    @(posedge mclk) {program_store_enable_n_n, ale, drv, dval} <= {ps, 1'b1, 1'b1, a};
    repeat (4) @(posedge mclk);
    ale <= 1'b0;
    repeat (5) @(posedge mclk);
    chk("latched", 16'(a), 16'(lat));
    if (wr) {dval, wr_n} <= {d, 1'b0};
    else {drv, rd_n} <= 2'b00;
    repeat (6) @(posedge mclk);
    #1 rq = mcu_bus;
    @(posedge mclk) {wr_n, rd_n} <= 2'b11;
    repeat (5) @(posedge mclk);
    {drv, program_store_enable_n_n} <= 2'b01;
    repeat (4) @(posedge mclk);
  endtask
  task automatic wait_idle;
    logic [7:0] s;
    s = 8'h01;
    repeat (4) if (s[0]) mcu_cyc(1'b0, 1'b1, dkc_pkg::REG_STAT, 8'h00, s);
    chk("busy", 16'h0000, 16'(s[dkc_pkg::STAT_BUSY_BIT]));
  endtask
  task automatic buf_op(input logic wr, input logic [15:0] a, input logic [7:0] d);
    mcu_cyc(1'b1, 1'b1, dkc_pkg::REG_ADDR_LO, a[7:0], q);
    mcu_cyc(1'b1, 1'b1, dkc_pkg::REG_ADDR_HI, a[15:8], q);
    mcu_cyc(1'b1, 1'b1, wr ? dkc_pkg::REG_DATA : dkc_pkg::REG_CTRL, wr ? d : 8'h01, q);
    wait_idle;
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge mclk);
    #1 chk("reset pins", 16'h007F, 16'({bank_n, we_n, oe_n, b_doe_n, mcu_oe_n, int_n, mrst}));
    @(posedge mclk) reset <= 1'b0;
    #1;
    while (mrst === 1'b1 && n < 40) begin
      @(posedge mclk);
      #1 n++;
    end
    chk("reset hold", 16'(dkc_pkg::RST_HOLD_CYCLES + 1), 16'(n));
    // ordinary buffer traffic: write, check ram and address, read back
    foreach (rows[i]) begin
      buf_op(1'b1, rows[i].a, rows[i].d);
      chk("ram byte", 16'(rows[i].d), 16'(sram.mem[rows[i].a]));
      chk("next addr", rows[i].nxt, b_addr);
      chk("bank", 16'(!rows[i].nxt[15]), 16'(bank_n));
      buf_op(1'b0, rows[i].a, 8'h00);
      mcu_cyc(1'b0, 1'b1, dkc_pkg::REG_DATA, 8'h00, q);
      chk("read back", 16'(rows[i].d), 16'(q));
    end
    // fetch cycles and an unmapped place must leave the bus alone
    mcu_cyc(1'b0, 1'b0, dkc_pkg::REG_DATA, 8'h00, q);
    chk("fetch read", 16'h0000, 16'(q));
    mcu_cyc(1'b0, 1'b1, 8'h80, 8'h00, q);
    chk("unmapped read", 16'h0000, 16'(q));
    mcu_cyc(1'b1, 1'b1, dkc_pkg::REG_ADDR_LO, 8'h10, q);
    mcu_cyc(1'b1, 1'b1, dkc_pkg::REG_ADDR_HI, 8'h00, q);
    mcu_cyc(1'b1, 1'b0, dkc_pkg::REG_ADDR_LO, 8'h55, q);
    mcu_cyc(1'b1, 1'b1, dkc_pkg::REG_DATA, 8'h77, q);
    wait_idle;
    chk("fetch write", 16'h0077, 16'(sram.mem[16'h0010]));
    // event interrupt masked, then enabled, then cleared
    for (int m = 0; m < 2; m++) begin
      mcu_cyc(1'b1, 1'b1, dkc_pkg::REG_IMASK, m ? 8'h02 : 8'h00, q);
      @(posedge mclk) ext <= 1'b1;
      @(posedge mclk) ext <= 1'b0;
      repeat (4) @(posedge mclk);
      #1 chk("int event", 16'(m == 0), 16'(int_n));
      mcu_cyc(1'b1, 1'b1, dkc_pkg::REG_STAT, 8'h02, q);
      chk("int clear", 16'h0001, 16'(int_n));
    end
    // completion interrupt from a buffer write
    mcu_cyc(1'b1, 1'b1, dkc_pkg::REG_IMASK, 8'h01, q);
    buf_op(1'b1, 16'h0120, 8'h99);
    chk("int done", 16'h0000, 16'(int_n));
    // register read-back: address after the access, mask and status
    mcu_cyc(1'b0, 1'b1, dkc_pkg::REG_ADDR_LO, 8'h00, q);
    chk("addr lo", 16'h0021, 16'(q));
    mcu_cyc(1'b0, 1'b1, dkc_pkg::REG_ADDR_HI, 8'h00, q);
    chk("addr hi", 16'h0001, 16'(q));
    mcu_cyc(1'b0, 1'b1, dkc_pkg::REG_IMASK, 8'h00, q);
    chk("mask", 16'h0001, 16'(q));
    mcu_cyc(1'b0, 1'b1, dkc_pkg::REG_STAT, 8'h00, q);
    chk("status", 16'h0002, 16'(q));
    end_of_test;
  end
endmodule
